// ==== sema_mbox_pkg.sv ====
// constants shared by the semaphore and mailbox block
// ****************************************************************
// Notes on behaviour
// - there are eight independent semaphores, each a one-bit state in bit 0 with upper bits read as zero.
// - reading a semaphore returns its state and, when it was free, takes it in the same access.
// - writing a zero to a semaphore's state releases it.
// - state zero means free, one means held, and every semaphore leaves reset free.
// - the summary register shows all eight semaphore states, one bit each, tracking every change.
// - reading the summary takes no semaphore and is only a snapshot.
// - two 32-bit mailboxes are freely read and written by both cores with no side effect on them.
// - either core may raise the interrupt aimed at either core.
// - the main core interrupt is high while its request bit and its enable bit are both one.
// - the auxiliary core interrupt is high while its request bit and its enable bit are both one.
// - the peripheral reset control returns every semaphore, mailbox and interrupt field to reset.
// - system, soft and power-on resets also return every field to its reset value.
// ****************************************************************
package sema_mbox_pkg;

	// ****************************************************************
	// sizes
	// ****************************************************************
	localparam int          ADDR_W   = 9;
	localparam int          DATA_W   = 32;
	localparam int          NUM_SEM  = 8;
	localparam int          NUM_EV   = 3;

	// ****************************************************************
	// register offsets (byte addresses)
	// ****************************************************************
	localparam logic [8:0]  OFF_SEM [NUM_SEM] = '{9'h000, 9'h004, 9'h008, 9'h00C,
	                                              9'h010, 9'h014, 9'h018, 9'h020};
	localparam logic [8:0]  OFF_IRQ_MAIN   = 9'h040;
	localparam logic [8:0]  OFF_MBOX0      = 9'h044;
	localparam logic [8:0]  OFF_IRQ_AUX    = 9'h048;
	localparam logic [8:0]  OFF_MBOX1      = 9'h04C;
	localparam logic [8:0]  OFF_SUMMARY    = 9'h100;
	localparam logic [8:0]  OFF_INT_STATUS = 9'h104;
	localparam logic [8:0]  OFF_INT_MASK   = 9'h108;

	// ****************************************************************
	// field positions
	// ****************************************************************
	localparam int          SEM_STATE_BIT = 0;
	localparam int          IRQ_EN_BIT    = 0;
	localparam int          IRQ_REQ_BIT   = 16;
	localparam int          EV_MBOX0      = 0;
	localparam int          EV_MBOX1      = 1;
	localparam int          EV_SEM_FREE   = 2;

	// ****************************************************************
	// reset values
	// ****************************************************************
	localparam logic [31:0] MBOX_RST      = 32'h0000_0000;
	localparam logic        SEM_RST       = 1'b0;
	localparam logic        IRQ_BIT_RST   = 1'b0;
	localparam logic [2:0]  EV_RST        = 3'h0;
	localparam logic [31:0] RDATA_RST     = 32'h0000_0000;

endpackage

// ==== sema_cell.sv ====
// one hardware semaphore bit with two-port take and release
`timescale 1ns/1ns
module sema_cell
	import sema_mbox_pkg::*;
(
	input  wire logic core_clk_in,
	input  wire logic rst_n_in,
	input  wire logic clr_in,
	input  wire logic take_main_in,
	input  wire logic take_aux_in,
	input  wire logic free_main_in,
	input  wire logic free_aux_in,
	output logic      view_main_out,
	output logic      view_aux_out,
	output logic      held_out
);

	typedef struct packed {
		logic held;
	} cell_s;

	cell_s st_r;
	cell_s st_nxt;

	// take beats release so a reader never sees zero without owning it
	always_comb begin
		st_nxt = st_r;
		if (clr_in) begin
			st_nxt.held = SEM_RST;
		end else if ((take_main_in || take_aux_in) && !st_r.held) begin
			st_nxt.held = 1'b1;
		end else if (free_main_in || free_aux_in) begin
			st_nxt.held = 1'b0;
		end
	end

	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			st_r.held <= SEM_RST;
		end else begin
			st_r <= st_nxt;
		end
	end

	// main port wins a same-cycle race: aux sees the bit main just took
	assign view_main_out = st_r.held;
	assign view_aux_out  = st_r.held | take_main_in;
	assign held_out      = st_r.held;

endmodule

// ==== sema_mbox.sv ====
// semaphore, mailbox and cross-core interrupt block with two register ports
`timescale 1ns/1ns
module sema_mbox
	import sema_mbox_pkg::*;
(
	input  wire logic              core_clk_in,
	input  wire logic              rst_n_in,
	input  wire logic              soft_rst_in,
	input  wire logic              periph_rst_in,
	input  wire logic [ADDR_W-1:0] main_addr_in,
	input  wire logic [DATA_W-1:0] main_wdata_in,
	input  wire logic              main_wr_in,
	input  wire logic              main_rd_in,
	output logic      [DATA_W-1:0] main_rdata_out,
	input  wire logic [ADDR_W-1:0] aux_addr_in,
	input  wire logic [DATA_W-1:0] aux_wdata_in,
	input  wire logic              aux_wr_in,
	input  wire logic              aux_rd_in,
	output logic      [DATA_W-1:0] aux_rdata_out,
	output logic                   main_core_irq_out,
	output logic                   aux_core_irq_out,
	output logic                   event_irq_out
);

	// ****************************************************************
	// state
	// ****************************************************************
	typedef struct packed {
		logic [DATA_W-1:0] mbox0;
		logic [DATA_W-1:0] mbox1;
		logic              irq_main_en;
		logic              irq_main_req;
		logic              irq_aux_en;
		logic              irq_aux_req;
		logic [NUM_EV-1:0] ev_status;
		logic [NUM_EV-1:0] ev_mask;
		logic [DATA_W-1:0] main_rdata;
		logic [DATA_W-1:0] aux_rdata;
	} regs_s;

	regs_s st_r;
	regs_s st_nxt;

	logic               clr;
	logic [NUM_SEM-1:0] main_take;
	logic [NUM_SEM-1:0] aux_take;
	logic [NUM_SEM-1:0] main_free;
	logic [NUM_SEM-1:0] aux_free;
	logic [NUM_SEM-1:0] view_main;
	logic [NUM_SEM-1:0] view_aux;
	logic [NUM_SEM-1:0] held;
	logic [NUM_EV-1:0]  ev_set;
	logic [NUM_EV-1:0]  ev_clr;

	// ****************************************************************
	// decode helpers
	// ****************************************************************
	// one-hot hit on the semaphore registers; offsets are not evenly spaced
	function automatic logic [NUM_SEM-1:0] sem_hit(input logic [ADDR_W-1:0] a);
		logic [NUM_SEM-1:0] h;
		h = '0;
		for (int i = 0; i < NUM_SEM; i++) begin
			h[i] = (a == OFF_SEM[i]);
		end
		return h;
	endfunction

	// read value of any register; view holds the semaphore bits this port sees
	function automatic logic [DATA_W-1:0] rd_mux(input logic [ADDR_W-1:0] a,
	                                             input logic [NUM_SEM-1:0] view,
	                                             input logic [NUM_SEM-1:0] summ,
	                                             input regs_s s);
		logic [DATA_W-1:0] d;
		logic [NUM_SEM-1:0] h;
		d = '0;
		h = sem_hit(a);
		if (|h) begin
			d[SEM_STATE_BIT] = |(h & view);
		end else begin
			unique case (a)
				OFF_IRQ_MAIN: begin
					d[IRQ_EN_BIT]  = s.irq_main_en;
					d[IRQ_REQ_BIT] = s.irq_main_req;
				end
				OFF_IRQ_AUX: begin
					d[IRQ_EN_BIT]  = s.irq_aux_en;
					d[IRQ_REQ_BIT] = s.irq_aux_req;
				end
				OFF_MBOX0:      d = s.mbox0;
				OFF_MBOX1:      d = s.mbox1;
				OFF_SUMMARY:    d[NUM_SEM-1:0] = summ;
				OFF_INT_STATUS: d[NUM_EV-1:0] = s.ev_status;
				OFF_INT_MASK:   d[NUM_EV-1:0] = s.ev_mask;
				default:        d = '0;
			endcase
		end
		return d;
	endfunction

	// ****************************************************************
	// semaphore bank
	// ****************************************************************
	// soft and peripheral resets act synchronously on the whole block
	assign clr       = soft_rst_in | periph_rst_in;
	assign main_take = {NUM_SEM{main_rd_in}} & sem_hit(main_addr_in);
	assign aux_take  = {NUM_SEM{aux_rd_in}} & sem_hit(aux_addr_in);
	assign main_free = {NUM_SEM{main_wr_in & ~main_wdata_in[SEM_STATE_BIT]}}
	                   & sem_hit(main_addr_in);
	assign aux_free  = {NUM_SEM{aux_wr_in & ~aux_wdata_in[SEM_STATE_BIT]}}
	                   & sem_hit(aux_addr_in);

	generate
		for (genvar g = 0; g < NUM_SEM; g++) begin : g_sem
			sema_cell u_cell (
				.core_clk_in   (core_clk_in),
				.rst_n_in      (rst_n_in),
				.clr_in        (clr),
				.take_main_in  (main_take[g]),
				.take_aux_in   (aux_take[g]),
				.free_main_in  (main_free[g]),
				.free_aux_in   (aux_free[g]),
				.view_main_out (view_main[g]),
				.view_aux_out  (view_aux[g]),
				.held_out      (held[g])
			);
		end
	endgenerate

	// ****************************************************************
	// events
	// ****************************************************************
	// mailbox writes and semaphore releases are the notifiable events
	always_comb begin
		ev_set = '0;
		ev_set[EV_MBOX0] = (main_wr_in && main_addr_in == OFF_MBOX0) ||
		                   (aux_wr_in && aux_addr_in == OFF_MBOX0);
		ev_set[EV_MBOX1] = (main_wr_in && main_addr_in == OFF_MBOX1) ||
		                   (aux_wr_in && aux_addr_in == OFF_MBOX1);
		ev_set[EV_SEM_FREE] = |(held & (main_free | aux_free));
		ev_clr = '0;
		if (main_wr_in && main_addr_in == OFF_INT_STATUS) begin
			ev_clr = ev_clr | main_wdata_in[NUM_EV-1:0];
		end
		if (aux_wr_in && aux_addr_in == OFF_INT_STATUS) begin
			ev_clr = ev_clr | aux_wdata_in[NUM_EV-1:0];
		end
	end

	// ****************************************************************
	// register file
	// ****************************************************************
	// aux write applied first so main wins a same-register collision;
	// software is expected to avoid such collisions on the mailboxes
	always_comb begin
		st_nxt = st_r;
		if (aux_wr_in) begin
			unique case (aux_addr_in)
				OFF_MBOX0:    st_nxt.mbox0 = aux_wdata_in;
				OFF_MBOX1:    st_nxt.mbox1 = aux_wdata_in;
				OFF_IRQ_MAIN: begin
					st_nxt.irq_main_en  = aux_wdata_in[IRQ_EN_BIT];
					st_nxt.irq_main_req = aux_wdata_in[IRQ_REQ_BIT];
				end
				OFF_IRQ_AUX: begin
					st_nxt.irq_aux_en  = aux_wdata_in[IRQ_EN_BIT];
					st_nxt.irq_aux_req = aux_wdata_in[IRQ_REQ_BIT];
				end
				OFF_INT_MASK: st_nxt.ev_mask = aux_wdata_in[NUM_EV-1:0];
				default: ;
			endcase
		end
		if (main_wr_in) begin
			unique case (main_addr_in)
				OFF_MBOX0:    st_nxt.mbox0 = main_wdata_in;
				OFF_MBOX1:    st_nxt.mbox1 = main_wdata_in;
				OFF_IRQ_MAIN: begin
					st_nxt.irq_main_en  = main_wdata_in[IRQ_EN_BIT];
					st_nxt.irq_main_req = main_wdata_in[IRQ_REQ_BIT];
				end
				OFF_IRQ_AUX: begin
					st_nxt.irq_aux_en  = main_wdata_in[IRQ_EN_BIT];
					st_nxt.irq_aux_req = main_wdata_in[IRQ_REQ_BIT];
				end
				OFF_INT_MASK: st_nxt.ev_mask = main_wdata_in[NUM_EV-1:0];
				default: ;
			endcase
		end
		// new events win over a write-one clear in the same cycle
		st_nxt.ev_status = (st_r.ev_status & ~ev_clr) | ev_set;
		// read data lives one cycle only, zero otherwise
		st_nxt.main_rdata = main_rd_in ? rd_mux(main_addr_in, view_main, held, st_r) : RDATA_RST;
		st_nxt.aux_rdata  = aux_rd_in  ? rd_mux(aux_addr_in, view_aux, held, st_r)   : RDATA_RST;
		if (clr) begin
			st_nxt.mbox0        = MBOX_RST;
			st_nxt.mbox1        = MBOX_RST;
			st_nxt.irq_main_en  = IRQ_BIT_RST;
			st_nxt.irq_main_req = IRQ_BIT_RST;
			st_nxt.irq_aux_en   = IRQ_BIT_RST;
			st_nxt.irq_aux_req  = IRQ_BIT_RST;
			st_nxt.ev_status    = EV_RST;
			st_nxt.ev_mask      = EV_RST;
			st_nxt.main_rdata   = RDATA_RST;
			st_nxt.aux_rdata    = RDATA_RST;
		end
	end

	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			st_r.mbox0        <= MBOX_RST;
			st_r.mbox1        <= MBOX_RST;
			st_r.irq_main_en  <= IRQ_BIT_RST;
			st_r.irq_main_req <= IRQ_BIT_RST;
			st_r.irq_aux_en   <= IRQ_BIT_RST;
			st_r.irq_aux_req  <= IRQ_BIT_RST;
			st_r.ev_status    <= EV_RST;
			st_r.ev_mask      <= EV_RST;
			st_r.main_rdata   <= RDATA_RST;
			st_r.aux_rdata    <= RDATA_RST;
		end else begin
			st_r <= st_nxt;
		end
	end

	// ****************************************************************
	// outputs
	// ****************************************************************
	// core interrupt lines are plain ands of flops and the event line an or of such ands, so they never glitch on bus activity
	assign main_rdata_out    = st_r.main_rdata;
	assign aux_rdata_out     = st_r.aux_rdata;
	assign main_core_irq_out = st_r.irq_main_en & st_r.irq_main_req;
	assign aux_core_irq_out  = st_r.irq_aux_en & st_r.irq_aux_req;
	assign event_irq_out     = |(st_r.ev_status & st_r.ev_mask);

	// ****************************************************************
	// checks
	// ****************************************************************
	default clocking cb @(posedge core_clk_in);
	endclocking
	default disable iff (!rst_n_in);

	logic main_sem_rd;
	logic aux_sem_rd;
	logic main_takes_free;
	logic same_sem;
	assign main_sem_rd     = main_rd_in && |sem_hit(main_addr_in);
	assign aux_sem_rd      = aux_rd_in && |sem_hit(aux_addr_in);
	assign main_takes_free = |(main_take & ~held);
	assign same_sem        = main_addr_in == aux_addr_in;

	logic aux_takes_free;
	logic main_reads_held;
	logic sem_quiet;
	// aux take only counts when main is not racing it for the same bit
	assign aux_takes_free  = |(aux_take & ~held & ~main_take);
	assign main_reads_held = |(main_take & held);
	assign sem_quiet       = !clr && main_take == '0 && aux_take == '0
	                         && main_free == '0 && aux_free == '0;

	// ****************************************************************
	// semaphore checks
	// ****************************************************************
	// reserved bits stay zero on both ports
	a_sem_upper_zero: assert property (main_sem_rd
		|=> main_rdata_out[DATA_W-1:1] == '0)
		else $error("semaphore read shows nonzero upper bits");
	a_aux_upper_zero: assert property (aux_sem_rd
		|=> aux_rdata_out[DATA_W-1:1] == '0)
		else $error("aux semaphore read shows nonzero upper bits");

	// a read of a free bit returns zero and leaves it held; a held bit reads one
	a_sem_take_free: assert property (main_takes_free && !clr
		|=> main_rdata_out[0] == 1'b0 && (held & $past(main_take)) != '0)
		else $error("free semaphore read did not take it");
	a_aux_take_free: assert property (aux_takes_free && !clr
		|=> aux_rdata_out[0] == 1'b0 && (held & $past(aux_take)) != '0)
		else $error("free semaphore read by aux did not take it");
	a_held_reads_one: assert property (main_reads_held && !clr
		|=> main_rdata_out[0] == 1'b1)
		else $error("held semaphore read as free");

	// zero writes release; nothing but an access or a clear moves a bit
	a_sem_release: assert property (|main_free && !aux_rd_in && !clr
		|=> (held & $past(main_free)) == '0)
		else $error("semaphore not released by zero write");
	a_aux_release: assert property (|aux_free && !main_rd_in && !clr
		|=> (held & $past(aux_free)) == '0)
		else $error("semaphore not released by aux zero write");
	a_clear_frees: assert property (clr |=> held == '0 && main_rdata_out == '0)
		else $error("clear left a semaphore held");
	a_sem_keep: assert property (sem_quiet |=> held == $past(held))
		else $error("semaphore changed without an access");

	// summary mirrors the bits and takes none of them; a clear drops the read
	a_summary_view: assert property (main_rd_in && main_addr_in == OFF_SUMMARY
		&& !clr |=> main_rdata_out == {{(DATA_W-NUM_SEM){1'b0}}, $past(held)})
		else $error("summary differs from semaphore states");
	a_aux_summary_view: assert property (aux_rd_in && aux_addr_in == OFF_SUMMARY
		&& !clr |=> aux_rdata_out == {{(DATA_W-NUM_SEM){1'b0}}, $past(held)})
		else $error("aux summary differs from semaphore states");
	a_summary_no_take: assert property (main_rd_in && main_addr_in == OFF_SUMMARY
		&& !aux_rd_in && !aux_wr_in && !clr |=> held == $past(held))
		else $error("summary read changed a semaphore");
	a_race_one_wins: assert property (main_sem_rd && aux_sem_rd && same_sem
		&& main_takes_free && !clr |=> main_rdata_out[0] == 1'b0 && aux_rdata_out[0] == 1'b1)
		else $error("both cores won one semaphore");

	// ****************************************************************
	// mailbox and interrupt checks
	// ****************************************************************
	// a word written by one core is read back by the other on the next cycle
	a_mbox_readback: assert property (main_wr_in && main_addr_in == OFF_MBOX1
		&& !clr ##1 aux_rd_in && aux_addr_in == OFF_MBOX1 && !main_wr_in && !aux_wr_in && !clr
		|=> aux_rdata_out == $past(main_wdata_in, 2))
		else $error("mailbox readback mismatch");

	// cross-core raise, and removal by the request or the enable bit
	a_main_irq_raise: assert property (aux_wr_in && aux_addr_in == OFF_IRQ_MAIN
		&& aux_wdata_in[IRQ_EN_BIT] && aux_wdata_in[IRQ_REQ_BIT] && !main_wr_in && !clr
		|=> main_core_irq_out ##1 (main_core_irq_out || $past(main_wr_in || aux_wr_in || clr)))
		else $error("main core interrupt not raised");
	a_main_irq_drop: assert property (main_wr_in && main_addr_in == OFF_IRQ_MAIN
		&& !main_wdata_in[IRQ_REQ_BIT] && !aux_wr_in |=> !main_core_irq_out)
		else $error("main core interrupt not removed");
	a_aux_irq_raise: assert property (main_wr_in && main_addr_in == OFF_IRQ_AUX
		&& main_wdata_in[IRQ_EN_BIT] && main_wdata_in[IRQ_REQ_BIT] && !clr |=> aux_core_irq_out)
		else $error("aux core interrupt not raised");
	a_aux_irq_drop: assert property (aux_wr_in && aux_addr_in == OFF_IRQ_AUX
		&& !aux_wdata_in[IRQ_EN_BIT] && !main_wr_in |=> !aux_core_irq_out)
		else $error("aux core interrupt not removed");

	// synchronous clears wipe the whole block in one cycle
	a_soft_reset: assert property (soft_rst_in
		|=> !main_core_irq_out && !aux_core_irq_out && !event_irq_out && held == '0)
		else $error("soft reset left state behind");
	a_periph_reset: assert property (periph_rst_in
		|=> !main_core_irq_out && !aux_core_irq_out && !event_irq_out && held == '0)
		else $error("peripheral reset left state behind");

	// ****************************************************************
	// cover points
	// ****************************************************************
	// the race, a busy summary, a raised line, a pending release and a handover
	c_race:     cover property (main_sem_rd && aux_sem_rd && same_sem && main_takes_free);
	c_summary:  cover property (main_rd_in && main_addr_in == OFF_SUMMARY && held != '0);
	c_irq_main: cover property (!main_core_irq_out ##1 main_core_irq_out);
	c_event:    cover property (event_irq_out && st_r.ev_status[EV_SEM_FREE]);
	c_mbox:     cover property (main_wr_in && main_addr_in == OFF_MBOX1
		##1 aux_rd_in && aux_addr_in == OFF_MBOX1);

endmodule

// ==== core_model.sv ====
// bus master model of one processor core on its register port
`timescale 1ns/1ns
module core_model
	import sema_mbox_pkg::*;
(
	input  wire logic              core_clk_in,
	output logic      [ADDR_W-1:0] addr_out,
	output logic      [DATA_W-1:0] wdata_out,
	output logic                   wr_out,
	output logic                   rd_out,
	input  wire logic [DATA_W-1:0] rdata_in
);
	// ****************************************************************
	// bus cycles
	// ****************************************************************
	// idle port at time zero
	initial begin
		addr_out  = '0;
		wdata_out = '0;
		wr_out    = 1'b0;
		rd_out    = 1'b0;
	end

	// one write strobe; caller stands just after a rising edge
	task automatic write(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		addr_out  <= a;
		wdata_out <= d;
		wr_out    <= 1'b1;
		@(posedge core_clk_in);
		// released lines flip so stale values never look valid
		wr_out    <= 1'b0;
		wdata_out <= ~d;
		addr_out  <= ~a;
		@(posedge core_clk_in);
	endtask

	// one read strobe; data taken only in the cycle after it
	task automatic read(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
		addr_out <= a;
		rd_out   <= 1'b1;
		@(posedge core_clk_in);
		rd_out   <= 1'b0;
		addr_out <= ~a;
		@(posedge core_clk_in);
		d = rdata_in;
	endtask
endmodule

// ==== tb_top.sv ====
// self-checking bench for the semaphore and mailbox block
`timescale 1ns/1ns
module tb_top
	import sema_mbox_pkg::*;
;
	logic              core_clk_in;
	logic              rst_n_in;
	logic              soft_rst_in;
	logic              periph_rst_in;
	logic [ADDR_W-1:0] m_addr, a_addr;
	logic [DATA_W-1:0] m_wdata, a_wdata, m_rdata, a_rdata;
	logic              m_wr, m_rd, a_wr, a_rd;
	logic              main_irq, aux_irq, ev_irq;
	int                errors;
	int                total_checks;

	sema_mbox dut_u (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in),
		.soft_rst_in(soft_rst_in), .periph_rst_in(periph_rst_in),
		.main_addr_in(m_addr), .main_wdata_in(m_wdata), .main_wr_in(m_wr),
		.main_rd_in(m_rd), .main_rdata_out(m_rdata),
		.aux_addr_in(a_addr), .aux_wdata_in(a_wdata), .aux_wr_in(a_wr),
		.aux_rd_in(a_rd), .aux_rdata_out(a_rdata),
		.main_core_irq_out(main_irq), .aux_core_irq_out(aux_irq), .event_irq_out(ev_irq));
	core_model main_core_u (.core_clk_in(core_clk_in), .addr_out(m_addr), .wdata_out(m_wdata),
		.wr_out(m_wr), .rd_out(m_rd), .rdata_in(m_rdata));
	core_model aux_core_u (.core_clk_in(core_clk_in), .addr_out(a_addr), .wdata_out(a_wdata),
		.wr_out(a_wr), .rd_out(a_rd), .rdata_in(a_rdata));

	// ****************************************************************
	// helpers
	// ****************************************************************
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		total_checks++;
		if (got !== exp) begin
			errors++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic rchk(input bit aux, input logic [8:0] a, input logic [31:0] exp,
		input string what);
		logic [31:0] d;
		if (aux) aux_core_u.read(a, d);
		else main_core_u.read(a, d);
		chk(what, exp, d);
	endtask

	task automatic wr(input bit aux, input logic [8:0] a, input logic [31:0] d);
		if (aux) aux_core_u.write(a, d);
		else main_core_u.write(a, d);
	endtask

	task automatic end_sim();
		if (errors == 0 && total_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	// ****************************************************************
	// scenarios
	// ****************************************************************
	// everything but semaphores and the mask is read as zero; 0x01C is a hole in the map
	task automatic t_reset_vals();
		logic [8:0] regs [7] = '{OFF_SUMMARY, OFF_IRQ_MAIN, OFF_MBOX0, OFF_IRQ_AUX,
			OFF_MBOX1, OFF_INT_STATUS, 9'h01C};
		foreach (regs[i]) rchk(i[0], regs[i], 32'h0, "reset reg");
		chk("irqs", 32'h0, {29'h0, main_irq, aux_irq, ev_irq});
	endtask

	// take every semaphore by reading, summary tracks, then release
	task automatic t_take_release();
		for (int i = 0; i < NUM_SEM; i++) begin
			rchk(1, OFF_SUMMARY, (32'h1 << i) - 1, "summary before");
			rchk(i[0], OFF_SEM[i], 32'h0, "first take");
			rchk(!i[0], OFF_SEM[i], 32'h1, "second read");
		end
		rchk(0, OFF_SUMMARY, 32'h0000_00FF, "summary all");
		wr(0, OFF_SEM[2], 32'h1);
		wr(1, 9'h01C, 32'h0);
		rchk(0, OFF_SUMMARY, 32'h0000_00FF, "ignored writes");
		for (int i = 0; i < NUM_SEM; i += 2) wr(i[1], OFF_SEM[i], 32'h0);
		rchk(1, OFF_SUMMARY, 32'h0000_00AA, "half free");
		for (int i = 1; i < NUM_SEM; i += 2) wr(0, OFF_SEM[i], 32'h0);
		rchk(0, OFF_SUMMARY, 32'h0, "all free");
	endtask

	// both cores grab one free semaphore in the same cycle
	task automatic t_race();
		logic [31:0] dm, da;
		fork
			main_core_u.read(OFF_SEM[3], dm);
			aux_core_u.read(OFF_SEM[3], da);
		join
		chk("race main", 32'h0, dm);
		chk("race aux", 32'h1, da);
		rchk(1, OFF_SUMMARY, 32'h0000_0008, "race summary");
		wr(1, OFF_SEM[3], 32'h0);
	endtask

	// each core owns one mailbox while writing, so writes never collide
	task automatic t_mailbox();
		logic [31:0] d;
		fork
			wr(0, OFF_MBOX0, 32'hA5A5_5A5A);
			wr(1, OFF_MBOX1, 32'h1234_5678);
		join
		rchk(1, OFF_MBOX0, 32'hA5A5_5A5A, "mbox0");
		rchk(1, OFF_MBOX0, 32'hA5A5_5A5A, "mbox0 again");
		rchk(0, OFF_MBOX1, 32'h1234_5678, "mbox1");
		// main hands a word to aux, which reads it on the very next cycle
		fork
			main_core_u.write(OFF_MBOX1, 32'h0F0F_C3C3);
			begin
				@(posedge core_clk_in);
				aux_core_u.read(OFF_MBOX1, d);
			end
		join
		chk("mbox handover", 32'h0F0F_C3C3, d);
	endtask

	// cross-core interrupts: raise, drop by request, drop by enable
	task automatic t_irq();
		logic [8:0] a;
		for (int t = 0; t < 2; t++) begin
			a = t[0] ? OFF_IRQ_AUX : OFF_IRQ_MAIN;
			wr(!t[0], a, 32'h0001_0001);
			chk("irq pair", t[0] ? 32'h1 : 32'h2, {30'h0, main_irq, aux_irq});
			wr(t[0], a, 32'h0000_0001);
			chk("irq req off", 32'h0, {30'h0, main_irq, aux_irq});
			rchk(t[0], a, 32'h0000_0001, "irq reg");
			wr(t[0], a, 32'h0001_0001);
			chk("irq self", t[0] ? 32'h1 : 32'h2, {30'h0, main_irq, aux_irq});
			wr(t[0], a, 32'h0001_0000);
			chk("irq en off", 32'h0, {30'h0, main_irq, aux_irq});
			wr(t[0], a, 32'h0);
		end
	endtask

	// event status: all three sources, mask gate, write-one clear
	task automatic t_event();
		wr(0, OFF_INT_STATUS, 32'h7);
		rchk(1, OFF_INT_STATUS, 32'h0, "ev cleared");
		rchk(0, OFF_SEM[6], 32'h0, "take six");
		wr(1, OFF_SEM[6], 32'h0);
		wr(0, OFF_MBOX0, 32'h1);
		wr(1, OFF_MBOX1, 32'h2);
		rchk(0, OFF_INT_STATUS, 32'h7, "ev status");
		chk("ev masked", 32'h0, {31'h0, ev_irq});
		wr(1, OFF_INT_MASK, 32'h4);
		rchk(1, OFF_INT_MASK, 32'h4, "ev mask");
		chk("ev unmasked", 32'h1, {31'h0, ev_irq});
		wr(0, OFF_INT_STATUS, 32'h4);
		rchk(0, OFF_INT_STATUS, 32'h3, "ev w1c");
		chk("ev dropped", 32'h0, {31'h0, ev_irq});
	endtask

	// peripheral, soft and full resets each wipe all state
	task automatic t_clears();
		for (int k = 0; k < 3; k++) begin
			rchk(0, OFF_SEM[5], 32'h0, "pre take");
			wr(1, OFF_MBOX1, 32'hFFFF_FFFF);
			wr(1, OFF_IRQ_MAIN, 32'h0001_0001);
			wr(0, OFF_INT_MASK, 32'h7);
			chk("pre irq", 32'h3, {30'h0, main_irq, ev_irq});
			if (k == 0) periph_rst_in <= 1'b1;
			else if (k == 1) soft_rst_in <= 1'b1;
			else rst_n_in <= 1'b0;
			@(posedge core_clk_in);
			periph_rst_in <= 1'b0;
			soft_rst_in <= 1'b0;
			rst_n_in <= 1'b1;
			@(posedge core_clk_in);
			chk("post irq", 32'h0, {29'h0, main_irq, aux_irq, ev_irq});
			rchk(1, OFF_SUMMARY, 32'h0, "post summary");
			rchk(0, OFF_MBOX1, 32'h0, "post mbox");
			rchk(1, OFF_IRQ_MAIN, 32'h0, "post irq reg");
			rchk(0, OFF_INT_MASK, 32'h0, "post mask");
		end
	endtask

	// ****************************************************************
	// clock, reset, sequence and watchdog
	// ****************************************************************
	initial begin
		core_clk_in = 1'b0;
		forever #5 core_clk_in = ~core_clk_in;
	end

	initial begin
		errors = 0;
		total_checks = 0;
		rst_n_in = 1'b0;
		soft_rst_in = 1'b0;
		periph_rst_in = 1'b0;
		repeat (16) @(posedge core_clk_in);
		rst_n_in <= 1'b1;
		@(posedge core_clk_in);
		t_reset_vals();
		t_take_release();
		t_race();
		t_mailbox();
		t_irq();
		t_event();
		t_clears();
		end_sim();
	end

	// whole run needs well under a thousand cycles
	initial begin
		repeat (20000) @(posedge core_clk_in);
		errors++;
		end_sim();
	end
endmodule
